// >>> lds_fault_mon.v
/*
 * Fault monitor: sticky capture of each fault source and the combined fault level.
 * Assumes all sources are already in the core clock domain.
 */
`timescale 1ns/1ns
`include "lds_regs.vh"

module lds_fault_mon #(
    parameter N = `LDS_FLT_WIDTH
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         reset,
    // Sources and clear
    input  wire [N-1:0] fault_src,
    input  wire         flags_clear,
    // Results
    output wire [N-1:0] fault_flags,
    output wire         fault_any
);
    reg [N-1:0] flags_reg;
    genvar i;

    generate
        for (i = 0; i < N; i = i + 1) begin : g_flag
            // A source firing in the clearing cycle stays recorded
            always @(posedge core_clk) begin
                if (reset) begin
                    flags_reg[i] <= 1'b0;
                end else if (fault_src[i]) begin
                    flags_reg[i] <= 1'b1;
                end else if (flags_clear) begin
                    flags_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign fault_flags = flags_reg;
    // Live sources show at once, captured ones until software reads them
    assign fault_any   = |flags_reg | |fault_src;
endmodule

// >>> lds_host_model.sv
/* Host model: sends serial frames on an 80 ns link clock, captures readback.
   Assumes the port samples every link pin with its own core clock. */
`timescale 1ns/1ns
module lds_host_model (
    // Link pins
    output logic sclk,
    output logic frame_sel_n,
    output logic serial_in_line,
    input  wire  serial_out_line,
    input  wire  serial_out_oe_n
);
    // A released readback line reads as its inverse, so late driving shows up
    wire rb_seen = serial_out_oe_n ? ~serial_out_line : serial_out_line;

    initial begin
        sclk = 1'b1;
        frame_sel_n = 1'b1;
        serial_in_line = 1'b0;
    end

    // Clock stands high between frames; data line is inverted when released
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        frame_sel_n = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_line = tx[i];
            #40 sclk = 1'b0;
            rx = {rx[30:0], rb_seen};
            #40 sclk = 1'b1;
        end
        #40 frame_sel_n = 1'b1;
        serial_in_line = ~serial_in_line;
        #80;
    endtask

    // Activity with no frame open, which the port must ignore
    task automatic noise();
        repeat (5) begin
            #40 sclk = 1'b0;
            serial_in_line = ~serial_in_line;
            #40 sclk = 1'b1;
        end
    endtask
endmodule

// >>> lds_regs.vh
/*
 * Constants of the loop converter serial port: register offsets, field positions,
 * reset values and timing counts.
 * Assumes a 100 MHz core clock and a 32-bit register port with byte addresses.
 */
`ifndef LDS_REGS_VH
`define LDS_REGS_VH

`define LDS_CLK_MHZ          100
`define LDS_SCLK_MAX_MHZ     30
`define LDS_FRAME_BITS       24
`define LDS_WDOG_TIME_US     1000
`define LDS_WDOG_CYCLES      (`LDS_WDOG_TIME_US * `LDS_CLK_MHZ)

`define LDS_ADDR_CTRL        8'h00
`define LDS_ADDR_STATUS      8'h04
`define LDS_ADDR_IRQ_STAT    8'h08
`define LDS_ADDR_IRQ_MASK    8'h0c
`define LDS_ADDR_RX_WORD     8'h10
`define LDS_ADDR_OUT_WORD    8'h14
`define LDS_ADDR_READBACK    8'h18
`define LDS_ADDR_FAULT       8'h1c

`define LDS_CTRL_WDOG_EN     0
`define LDS_CTRL_RESET       32'h0000_0000
`define LDS_READBACK_RESET   32'h0000_0000

`define LDS_ST_FAULT         0
`define LDS_ST_PENDING       1
`define LDS_ST_ALARM_UP      2
`define LDS_ST_RES_INT       3
`define LDS_ST_SPAN0         4
`define LDS_ST_SPAN1         5
`define LDS_ST_FRAME         6

`define LDS_IRQ_RX           0
`define LDS_IRQ_OUT          1
`define LDS_IRQ_FAULT        2
`define LDS_IRQ_WIDTH        3

`define LDS_FLT_IF_LOSS      0
`define LDS_FLT_FRAME_ERR    1
`define LDS_FLT_RANGE        2
`define LDS_FLT_VLOOP        3
`define LDS_FLT_TEMP         4
`define LDS_FLT_WIDTH        5

`endif

// >>> lds_serial_port.v
/*
 * Serial host port of a loop-powered current-output converter: frame shifter,
 * readback, input and output word registers, load strobe, fault alert, strap pins,
 * register port and interrupt.
 * Assumes every pin is asynchronous to core_clk and the serial clock is at least
 * three core clocks high and low, so edges are found by sampling.
 */
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
`include "lds_regs.vh"

module lds_serial_port #(
    parameter FRAME_BITS  = `LDS_FRAME_BITS,
    parameter CNT_W       = 6,
    parameter WDOG_CYCLES = `LDS_WDOG_CYCLES
) (
    // Clock and reset
    input  wire                  core_clk,
    input  wire                  reset,
    // Serial pins
    input  wire                  sclk,
    input  wire                  frame_sel_n,
    input  wire                  serial_in_line,
    input  wire                  output_load_n,
    output wire                  serial_out_line,
    output wire                  serial_out_oe_n,
    // Strap pins
    input  wire                  alarm_dir_pin,
    input  wire                  res_sel_pin,
    input  wire                  loop_span_sel0,
    input  wire                  loop_span_sel1,
    // Analog fault sources
    input  wire                  loop_range_fault,
    input  wire                  loop_voltage_low,
    input  wire                  over_temp,
    // Converter side
    output reg [FRAME_BITS-1:0]  input_word_reg,
    output reg [FRAME_BITS-1:0]  output_word_reg,
    output reg                   output_update_reg,
    output wire                  alarm_upscale,
    output wire                  use_internal_res,
    output wire [1:0]            loop_span,
    output wire                  fault,
    // Register port
    input  wire [7:0]            reg_addr,
    input  wire [31:0]           reg_wdata,
    input  wire                  reg_wr,
    input  wire                  reg_rd,
    output reg [31:0]            reg_rdata,
    output wire                  irq
);
    localparam NPIN = 11;
    localparam P_SCLK = 0;
    localparam P_SEL  = 1;
    localparam P_SDI  = 2;
    localparam P_LD   = 3;
    localparam P_ALM  = 4;
    localparam P_RES  = 5;
    localparam P_SP0  = 6;
    localparam P_SP1  = 7;
    localparam P_RNG  = 8;
    localparam P_VLP  = 9;
    localparam P_TMP  = 10;
    localparam [CNT_W-1:0] FRAME_CNT = FRAME_BITS;
    localparam [31:0] WDOG_LAST = WDOG_CYCLES - 1;
    localparam [NPIN-1:0] PIN_IDLE = 11'h00b;

    // Pin synchronisers and history for edge finding
    reg  [NPIN-1:0]       meta_reg;
    reg  [NPIN-1:0]       sync_reg;
    reg  [3:0]            prev_reg;
    wire [NPIN-1:0]       pin_vec;

    reg  [FRAME_BITS-1:0] shift_reg;
    reg  [CNT_W-1:0]      bit_cnt_reg;
    reg                   rb_bit_reg;
    reg                   pending_reg;
    reg                   frame_err_reg;
    reg                   rx_done_reg;
    reg  [31:0]           wdog_cnt_reg;
    reg                   wdog_lost_reg;

    reg  [31:0]           ctrl_reg;
    reg  [31:0]           readback_reg;
    reg  [`LDS_IRQ_WIDTH-1:0] irq_stat_reg;
    reg  [`LDS_IRQ_WIDTH-1:0] irq_stat_next;
    reg  [`LDS_IRQ_WIDTH-1:0] irq_mask_reg;
    reg                   fault_prev_reg;

    wire                  sclk_rise;
    wire                  sclk_fall;
    wire                  sel_fall;
    wire                  sel_rise;
    wire                  ld_fall;
    wire                  in_frame;
    wire                  frame_ok;
    wire                  load_now;
    wire [`LDS_FLT_WIDTH-1:0] fault_src;
    wire [`LDS_FLT_WIDTH-1:0] fault_flags;
    wire                  fault_any;
    wire                  fault_rd;
    wire                  stat_rd;
    reg  [31:0]           status_word;

    assign pin_vec[P_SCLK] = sclk;
    assign pin_vec[P_SEL]  = frame_sel_n;
    assign pin_vec[P_SDI]  = serial_in_line;
    assign pin_vec[P_LD]   = output_load_n;
    assign pin_vec[P_ALM]  = alarm_dir_pin;
    assign pin_vec[P_RES]  = res_sel_pin;
    assign pin_vec[P_SP0]  = loop_span_sel0;
    assign pin_vec[P_SP1]  = loop_span_sel1;
    assign pin_vec[P_RNG]  = loop_range_fault;
    assign pin_vec[P_VLP]  = loop_voltage_low;
    assign pin_vec[P_TMP]  = over_temp;

    // Reset to the idle levels of clock, select and load, so no false edge follows reset
    always @(posedge core_clk) begin
        if (reset) begin
            meta_reg <= PIN_IDLE;
            sync_reg <= PIN_IDLE;
            prev_reg <= 4'hb;
        end else begin
            meta_reg <= pin_vec;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg[3:0];
        end
    end

    assign sclk_rise = sync_reg[P_SCLK] & ~prev_reg[P_SCLK];
    assign sclk_fall = ~sync_reg[P_SCLK] & prev_reg[P_SCLK];
    assign sel_fall  = ~sync_reg[P_SEL] & prev_reg[P_SEL];
    assign sel_rise  = sync_reg[P_SEL] & ~prev_reg[P_SEL];
    assign ld_fall   = ~sync_reg[P_LD] & prev_reg[P_LD];
    assign in_frame  = ~sync_reg[P_SEL] & ~prev_reg[P_SEL];
    assign frame_ok  = sel_rise & (bit_cnt_reg == FRAME_CNT);

    // Frame shifter; clock and data are ignored outside a frame
    always @(posedge core_clk) begin
        if (reset) begin
            shift_reg   <= {FRAME_BITS{1'b0}};
            bit_cnt_reg <= {CNT_W{1'b0}};
            rb_bit_reg  <= 1'b0;
        end else if (sel_fall) begin
            // First readback bit must stand before the host's first falling clock
            shift_reg   <= readback_reg[FRAME_BITS-1:0];
            bit_cnt_reg <= {CNT_W{1'b0}};
            rb_bit_reg  <= readback_reg[FRAME_BITS-1];
        end else if (in_frame) begin
            if (sclk_fall) begin
                shift_reg <= {shift_reg[FRAME_BITS-2:0], sync_reg[P_SDI]};
                // Saturate so an overlong frame cannot wrap back to a legal count
                if (bit_cnt_reg != {CNT_W{1'b1}}) begin
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                end
            end
            if (sclk_rise) begin
                rb_bit_reg <= shift_reg[FRAME_BITS-1];
            end
        end
    end

    assign serial_out_line = rb_bit_reg;
    assign serial_out_oe_n = sync_reg[P_SEL];

    // Input word register on each good frame, output word register under the load strobe
    assign load_now = (frame_ok & ~sync_reg[P_LD]) | (ld_fall & pending_reg);

    always @(posedge core_clk) begin
        if (reset) begin
            input_word_reg    <= {FRAME_BITS{1'b0}};
            output_word_reg   <= {FRAME_BITS{1'b0}};
            output_update_reg <= 1'b0;
            pending_reg       <= 1'b0;
            rx_done_reg       <= 1'b0;
            frame_err_reg     <= 1'b0;
        end else begin
            rx_done_reg       <= frame_ok;
            frame_err_reg     <= sel_rise & ~frame_ok;
            output_update_reg <= load_now;
            if (frame_ok) begin
                input_word_reg <= shift_reg;
            end
            if (frame_ok & ~sync_reg[P_LD]) begin
                output_word_reg <= shift_reg;
                pending_reg     <= 1'b0;
            end else if (frame_ok) begin
                pending_reg     <= 1'b1;
            end else if (ld_fall & pending_reg) begin
                output_word_reg <= input_word_reg;
                pending_reg     <= 1'b0;
            end
        end
    end

    // Loss of interface control: no good frame within the watchdog time
    always @(posedge core_clk) begin
        if (reset) begin
            wdog_cnt_reg  <= 32'h0000_0000;
            wdog_lost_reg <= 1'b0;
        end else if (frame_ok | ~ctrl_reg[`LDS_CTRL_WDOG_EN]) begin
            wdog_cnt_reg  <= 32'h0000_0000;
            wdog_lost_reg <= 1'b0;
        end else if (wdog_cnt_reg == WDOG_LAST) begin
            wdog_lost_reg <= 1'b1;
        end else begin
            wdog_cnt_reg  <= wdog_cnt_reg + 32'h0000_0001;
        end
    end

    assign fault_src[`LDS_FLT_IF_LOSS]   = wdog_lost_reg;
    assign fault_src[`LDS_FLT_FRAME_ERR] = frame_err_reg;
    assign fault_src[`LDS_FLT_RANGE]     = sync_reg[P_RNG];
    assign fault_src[`LDS_FLT_VLOOP]     = sync_reg[P_VLP];
    assign fault_src[`LDS_FLT_TEMP]      = sync_reg[P_TMP];
    assign fault_rd  = reg_rd & (reg_addr == `LDS_ADDR_FAULT);
    assign stat_rd   = reg_rd & (reg_addr == `LDS_ADDR_IRQ_STAT);

    lds_fault_mon #(
        .N           (`LDS_FLT_WIDTH)
    ) u_fault (
        .core_clk    (core_clk),
        .reset       (reset),
        .fault_src   (fault_src),
        .flags_clear (fault_rd),
        .fault_flags (fault_flags),
        .fault_any   (fault_any)
    );

    assign fault            = fault_any;
    assign alarm_upscale    = sync_reg[P_ALM];
    assign use_internal_res = sync_reg[P_RES];
    assign loop_span        = {sync_reg[P_SP1], sync_reg[P_SP0]};

    // Sticky interrupt causes; a new event beats a clearing read
    always @* begin
        irq_stat_next = irq_stat_reg;
        if (stat_rd) begin
            irq_stat_next = {`LDS_IRQ_WIDTH{1'b0}};
        end
        irq_stat_next[`LDS_IRQ_RX]    = irq_stat_next[`LDS_IRQ_RX] | rx_done_reg;
        irq_stat_next[`LDS_IRQ_OUT]   = irq_stat_next[`LDS_IRQ_OUT] | output_update_reg;
        irq_stat_next[`LDS_IRQ_FAULT] = irq_stat_next[`LDS_IRQ_FAULT] |
                                        (fault_any & ~fault_prev_reg);
    end

    always @(posedge core_clk) begin
        if (reset) begin
            irq_stat_reg   <= {`LDS_IRQ_WIDTH{1'b0}};
            fault_prev_reg <= 1'b0;
        end else begin
            irq_stat_reg   <= irq_stat_next;
            fault_prev_reg <= fault_any;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Live view of pins and state; reading it clears nothing
    always @* begin
        status_word                   = 32'h0000_0000;
        status_word[`LDS_ST_FAULT]    = fault_any;
        status_word[`LDS_ST_PENDING]  = pending_reg;
        status_word[`LDS_ST_ALARM_UP] = sync_reg[P_ALM];
        status_word[`LDS_ST_RES_INT]  = sync_reg[P_RES];
        status_word[`LDS_ST_SPAN0]    = sync_reg[P_SP0];
        status_word[`LDS_ST_SPAN1]    = sync_reg[P_SP1];
        status_word[`LDS_ST_FRAME]    = ~sync_reg[P_SEL];
    end

    // Register writes
    always @(posedge core_clk) begin
        if (reset) begin
            ctrl_reg     <= `LDS_CTRL_RESET;
            readback_reg <= `LDS_READBACK_RESET;
            irq_mask_reg <= {`LDS_IRQ_WIDTH{1'b0}};
        end else if (reg_wr) begin
            case (reg_addr)
                `LDS_ADDR_CTRL: begin
                    ctrl_reg <= {31'h0000_0000, reg_wdata[`LDS_CTRL_WDOG_EN]};
                end
                `LDS_ADDR_IRQ_MASK: begin
                    irq_mask_reg <= reg_wdata[`LDS_IRQ_WIDTH-1:0];
                end
                `LDS_ADDR_READBACK: begin
                    readback_reg <= reg_wdata;
                end
                default: begin
                    ctrl_reg <= ctrl_reg;
                end
            endcase
        end
    end

    // Register reads; data stand the cycle after the strobe only
    always @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `LDS_ADDR_CTRL:     reg_rdata <= ctrl_reg;
                `LDS_ADDR_STATUS:   reg_rdata <= status_word;
                `LDS_ADDR_IRQ_STAT: reg_rdata <= {29'h0000_0000, irq_stat_reg};
                `LDS_ADDR_IRQ_MASK: reg_rdata <= {29'h0000_0000, irq_mask_reg};
                `LDS_ADDR_RX_WORD:  reg_rdata <= {{(32-FRAME_BITS){1'b0}}, input_word_reg};
                `LDS_ADDR_OUT_WORD: reg_rdata <= {{(32-FRAME_BITS){1'b0}}, output_word_reg};
                `LDS_ADDR_READBACK: reg_rdata <= readback_reg;
                `LDS_ADDR_FAULT:    reg_rdata <= {27'h000_0000, fault_flags};
                default:            reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

// >>> lds_serial_port_asserts.sv
/* Checker for the loop converter serial port: frame, load, fault and strap timing.
   Assumes a 100 MHz core_clk and attachment by bind from the bench. */
`timescale 1ns/1ns
module lds_port_chk #(
    parameter FRAME_BITS = 24
) (
    // Clock and reset
    input wire                  core_clk,
    input wire                  reset,
    // Serial pins
    input wire                  sclk,
    input wire                  frame_sel_n,
    input wire                  output_load_n,
    input wire                  serial_out_line,
    input wire                  serial_out_oe_n,
    // Strap and fault pins
    input wire                  alarm_dir_pin,
    input wire                  res_sel_pin,
    input wire                  loop_span_sel0,
    input wire                  loop_span_sel1,
    input wire                  loop_range_fault,
    input wire                  loop_voltage_low,
    input wire                  over_temp,
    // Converter side
    input wire [FRAME_BITS-1:0] input_word_reg,
    input wire [FRAME_BITS-1:0] output_word_reg,
    input wire                  output_update_reg,
    input wire                  alarm_upscale,
    input wire                  use_internal_res,
    input wire [1:0]            loop_span,
    input wire                  fault
);
    reg [3:0] sel_hi_cnt;
    reg [3:0] sel_lo_cnt;
    reg [3:0] ld_lo_cnt;

    // Saturating ages of pin levels; the sync delay makes exact edges unusable
    always @(posedge core_clk) begin
        if (reset) begin
            sel_hi_cnt <= 4'hf;
            sel_lo_cnt <= 4'hf;
            ld_lo_cnt  <= 4'hf;
        end else begin
            sel_hi_cnt <= !frame_sel_n ? 4'h0 : sel_hi_cnt + {3'h0, ~&sel_hi_cnt};
            sel_lo_cnt <= frame_sel_n ? 4'h0 : sel_lo_cnt + {3'h0, ~&sel_lo_cnt};
            ld_lo_cnt  <= output_load_n ? 4'h0 : ld_lo_cnt + {3'h0, ~&ld_lo_cnt};
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_oe_idle; frame_sel_n [*4] |-> serial_out_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("readback driven idle");
    property p_oe_drive; !frame_sel_n [*4] |-> !serial_out_oe_n; endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("readback not driven");
    property p_rx_latch;
        $changed(input_word_reg) |-> frame_sel_n && sel_hi_cnt <= 4'h5;
    endproperty
    a_rx_latch: assert property (p_rx_latch) else $error("word off frame end");
    property p_out_cause;
        $changed(output_word_reg) |->
            !output_load_n && ((frame_sel_n && sel_hi_cnt <= 4'h5) || ld_lo_cnt <= 4'h5);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("stray output update");
    property p_out_copy; $changed(output_word_reg) |-> output_word_reg == input_word_reg;
    endproperty
    a_out_copy: assert property (p_out_copy) else $error("output not input word");
    property p_upd_pulse;
        $changed(output_word_reg) |-> output_update_reg ##1 !output_update_reg;
    endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse wrong");
    property p_defer; output_load_n [*8] |-> $stable(output_word_reg); endproperty
    a_defer: assert property (p_defer) else $error("update with load high");
    property p_fault;
        (over_temp || loop_range_fault || loop_voltage_low) [*3] |-> fault;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not raised");
    property p_alarm; $stable(alarm_dir_pin) [*4] |-> alarm_upscale == alarm_dir_pin;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm select wrong");
    property p_res; $stable(res_sel_pin) [*4] |-> use_internal_res == res_sel_pin;
    endproperty
    a_res: assert property (p_res) else $error("resistor select wrong");
    property p_span;
        $stable({loop_span_sel1, loop_span_sel0}) [*4] |->
            loop_span == {loop_span_sel1, loop_span_sel0};
    endproperty
    a_span: assert property (p_span) else $error("range select wrong");
    property p_rb_edge;
        $changed(serial_out_line) |->
            sclk || $past(sclk) || $past(sclk, 2) || frame_sel_n || sel_lo_cnt <= 4'h5;
    endproperty
    a_rb_edge: assert property (p_rb_edge) else $error("readback moved off clock rise");

    c_update: cover property ($changed(output_word_reg));
    c_pulse: cover property ($rose(output_update_reg));
    c_fault: cover property ($rose(fault));
endmodule

// >>> lds_serial_port_tb.sv
/* Testbench of the loop converter serial port: frames, load strobe, faults, straps.
   Assumes the host model drives the link pins. */
`timescale 1ns/1ns
module lds_serial_port_tb;
    logic        core_clk = 1'b0, reset = 1'b1, output_load_n = 1'b0;
    logic        alarm_dir_pin = 1'b0, res_sel_pin = 1'b0;
    logic        loop_span_sel0 = 1'b0, loop_span_sel1 = 1'b0;
    logic        loop_range_fault = 1'b0, loop_voltage_low = 1'b0, over_temp = 1'b0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, irq, fault, output_update_reg;
    logic        sclk, frame_sel_n, serial_in_line, serial_out_line, serial_out_oe_n;
    logic        alarm_upscale, use_internal_res;
    logic [1:0]  loop_span;
    logic [23:0] input_word_reg, output_word_reg;
    int          n_mismatch = 0, check_count = 0, cyc = 0;

    lds_serial_port #(.FRAME_BITS(24), .WDOG_CYCLES(200)) dut (.core_clk, .reset, .sclk,
        .frame_sel_n, .serial_in_line, .output_load_n, .serial_out_line, .serial_out_oe_n,
        .alarm_dir_pin, .res_sel_pin, .loop_span_sel0, .loop_span_sel1, .loop_range_fault,
        .loop_voltage_low, .over_temp, .input_word_reg, .output_word_reg, .output_update_reg,
        .alarm_upscale, .use_internal_res, .loop_span, .fault, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq);
    lds_host_model host (.sclk, .frame_sel_n, .serial_in_line, .serial_out_line,
        .serial_out_oe_n);

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("mismatches %0d of %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chkw({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chkw(reg_rdata, exp);
    endtask
    // Frames start a few ns after a core edge so the link phase is unrelated
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        @(posedge core_clk);
        #3 host.xfer(tx, n, rx);
        repeat (6) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset();
        chkb(serial_out_oe_n, 1'b1);
        chkw({8'h0, output_word_reg}, 32'h0);
        rdchk(8'h18, 32'h0);
        rdchk(8'h20, 32'h0);
    endtask
    task automatic t_load_low();
        logic [31:0] rx;
        wr(8'h18, 32'h00a5c3e1);
        frame(32'h003c5a96, 24, rx);
        chkw(rx, 32'h00a5c3e1);
        chkw({8'h0, input_word_reg}, 32'h003c5a96);
        chkw({8'h0, output_word_reg}, 32'h003c5a96);
        rdchk(8'h08, 32'h3);
    endtask
    task automatic t_defer();
        logic [31:0] rx;
        @(posedge core_clk) output_load_n <= 1'b1;
        frame(32'h00123456, 24, rx);
        chkw({8'h0, input_word_reg}, 32'h00123456);
        chkw({8'h0, output_word_reg}, 32'h003c5a96);
        @(posedge core_clk) output_load_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        chkw({8'h0, output_word_reg}, 32'h00123456);
        @(posedge core_clk);
        #3 host.noise();
        repeat (6) @(posedge core_clk);
        chkw({8'h0, input_word_reg}, 32'h00123456);
    endtask
    task automatic t_short();
        logic [31:0] rx;
        wr(8'h0c, 32'h4);
        frame(32'h00000abc, 23, rx);
        chkw({8'h0, input_word_reg}, 32'h00123456);
        chkb(fault, 1'b1);
        chkb(irq, 1'b1);
        rdchk(8'h1c, 32'h2);
        rdchk(8'h08, 32'h7);
        repeat (2) @(posedge core_clk);
        chkb(irq, 1'b0);
        chkb(fault, 1'b0);
    endtask
    task automatic t_sources();
        logic [31:0] rx;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk) {over_temp, loop_voltage_low, loop_range_fault} <= 3'h1 << i;
            repeat (4) @(posedge core_clk);
            chkb(fault, 1'b1);
            @(posedge core_clk) {over_temp, loop_voltage_low, loop_range_fault} <= 3'h0;
            repeat (4) @(posedge core_clk);
            rdchk(8'h1c, 32'h4 << i);
            repeat (2) @(posedge core_clk);
            chkb(fault, 1'b0);
        end
        wr(8'h00, 32'h1);
        repeat (260) @(posedge core_clk);
        chkb(fault, 1'b1);
        rdchk(8'h1c, 32'h1);
        wr(8'h00, 32'h0);
        frame(32'h00654321, 24, rx);
        rdchk(8'h1c, 32'h1);
        rdchk(8'h1c, 32'h0);
    endtask
    task automatic t_straps();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {loop_span_sel1, loop_span_sel0} <= 2'(i);
            alarm_dir_pin <= i[0];
            res_sel_pin <= ~i[0];
            repeat (5) @(posedge core_clk);
            chkb(alarm_upscale, i[0]);
            chkb(use_internal_res, ~i[0]);
            chkw({30'h0, loop_span}, 32'(i));
        end
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_load_low();
        t_defer();
        t_short();
        t_sources();
        t_straps();
        finish_test();
    end
endmodule

bind lds_serial_port lds_port_chk #(.FRAME_BITS(FRAME_BITS)) u_chk (.core_clk, .reset,
    .sclk, .frame_sel_n, .output_load_n, .serial_out_line, .serial_out_oe_n, .alarm_dir_pin,
    .res_sel_pin, .loop_span_sel0, .loop_span_sel1, .loop_range_fault, .loop_voltage_low,
    .over_temp, .input_word_reg, .output_word_reg, .output_update_reg, .alarm_upscale,
    .use_internal_res, .loop_span, .fault);
